// file: cpx_pkg.sv
package cpx_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int OPC_W = 10;
  localparam int DATA_W = 32;
  localparam int CC_W = 2;
  localparam int EXC_W = 6;
  localparam int INSTR_W = 32;
  localparam int REG_AW = 5;
  localparam int REG_N = 32;

  // ------------------------------------------------------------
  // Instruction fields that form the unit opcode, and the destination register field
  // ------------------------------------------------------------
  localparam int OPC_HI_BIT = 19;
  localparam int OPC_LO_MSB = 13;
  localparam int OPC_LO_LSB = 5;
  localparam int RD_LSB = 25;

  // ------------------------------------------------------------
  // Timing counts
  // ------------------------------------------------------------
  localparam logic [1:0] FLUSH_CYCLES = 2'h2;
  localparam logic [3:0] EU_LATENCY = 4'h4;

  // ------------------------------------------------------------
  // Register map for the Wishbone slave (word offsets in bytes)
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_INSTR = 8'h04;
  localparam logic [7:0] ADR_OPA = 8'h08;
  localparam logic [7:0] ADR_OPB = 8'h0C;
  localparam logic [7:0] ADR_STAT = 8'h10;
  localparam logic [7:0] ADR_IMASK = 8'h14;
  localparam logic [7:0] ADR_RESULT = 8'h18;
  localparam logic [7:0] ADR_CCEXC = 8'h1C;
  localparam logic [7:0] ADR_FSR = 8'h20;
  localparam logic [7:0] ADR_RDREG = 8'h24;

  // CTRL bits: write 1 to trap (issue is a write to INSTR); every CTRL write also loads the mode bit.
  localparam int CTRL_ISSUE = 0;
  localparam int CTRL_TRAP = 1;
  localparam int CTRL_PARALLEL = 2;

  // STAT bits (sticky events, cleared by reading STAT).
  localparam int ST_DONE = 0;
  localparam int ST_FLUSHED = 1;
  localparam int ST_FPTRAP = 2;
  localparam int ST_W = 3;

  // FSR field position of the queue-not-empty flag.
  localparam int FSR_QNE_BIT = 13;

  // Store-float-queue instruction: op=3, op3=6'h26.
  localparam logic [1:0] SFQ_OP = 2'h3;
  localparam logic [5:0] SFQ_OP3 = 6'h26;

  // Function used by the opcode path of the processor.
  function automatic logic [OPC_W-1:0] make_opcode(input logic [INSTR_W-1:0] ins);
    make_opcode = {ins[OPC_HI_BIT], ins[OPC_LO_MSB:OPC_LO_LSB]};
  endfunction

  function automatic logic is_store_queue(input logic [INSTR_W-1:0] ins);
    is_store_queue = (ins[31:30] == SFQ_OP) && (ins[24:19] == SFQ_OP3);
  endfunction

endpackage

// file: cpx_if.sv
`timescale 1ns/100ps
interface cpx_if;
  logic start;
  logic [cpx_pkg::OPC_W-1:0] opcode;
  logic load;
  logic [cpx_pkg::DATA_W-1:0] op_a;
  logic [cpx_pkg::DATA_W-1:0] op_b;
  logic flush;
  logic busy;
  logic [cpx_pkg::DATA_W-1:0] result;
  logic [cpx_pkg::CC_W-1:0] cc;
  logic [cpx_pkg::EXC_W-1:0] exc;

  modport proc (output start, opcode, load, op_a, op_b, flush,
                input busy, result, cc, exc);
  modport unit (input start, opcode, load, op_a, op_b, flush,
                output busy, result, cc, exc);
endinterface

// file: cpx_alu.sv
`timescale 1ns/100ps
module cpx_alu (
  // Operation select and operands
  input wire logic [cpx_pkg::OPC_W-1:0] opcode,
  input wire logic [cpx_pkg::DATA_W-1:0] a,
  input wire logic [cpx_pkg::DATA_W-1:0] b,
  // Result
  output logic [cpx_pkg::DATA_W-1:0] y,
  output logic [cpx_pkg::CC_W-1:0] cc,
  output logic [cpx_pkg::EXC_W-1:0] exc
);

  // ------------------------------------------------------------
  // Simple arithmetic selected by the low opcode bits.
  // ------------------------------------------------------------
  always_comb
  begin
    exc = '0;
    unique case (opcode[1:0])
      2'h0: y = a + b;
      2'h1: y = a - b;
      2'h2: y = a & b;
      2'h3: y = a ^ b;
    endcase
    if (opcode[1:0] == 2'h0 && (a[31] == b[31]) && (y[31] != a[31]))
      exc[0] = 1'b1; // Overflow flag.
    cc = {y[31], (y == '0)};
  end

endmodule

// file: cpx_unit.sv
`timescale 1ns/100ps
module cpx_unit (
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Processor side
  cpx_if.unit LINK
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum {U_IDLE, U_LOAD, U_BUSY} ustate_t;

  typedef struct packed {
    ustate_t st;
    logic [cpx_pkg::OPC_W-1:0] opc;
    logic [3:0] cnt;
    logic [cpx_pkg::DATA_W-1:0] a;
    logic [cpx_pkg::DATA_W-1:0] b;
    logic [cpx_pkg::DATA_W-1:0] res;
    logic [cpx_pkg::CC_W-1:0] cc;
    logic [cpx_pkg::EXC_W-1:0] exc;
  } ustate_all_t;

  ustate_all_t s_reg;
  ustate_all_t s_next;
  logic [cpx_pkg::DATA_W-1:0] alu_y;
  logic [cpx_pkg::CC_W-1:0] alu_cc;
  logic [cpx_pkg::EXC_W-1:0] alu_exc;
  logic [cpx_pkg::DATA_W-1:0] alu_a;
  logic [cpx_pkg::DATA_W-1:0] alu_b;

  // In the load cycle the operands are still on the link, not yet in the registers.
  assign alu_a = (s_reg.st == U_LOAD) ? LINK.op_a : s_reg.a;
  assign alu_b = (s_reg.st == U_LOAD) ? LINK.op_b : s_reg.b;

  cpx_alu alu (
    .opcode(s_reg.opc),
    .a(alu_a),
    .b(alu_b),
    .y(alu_y),
    .cc(alu_cc),
    .exc(alu_exc)
  );

  // ------------------------------------------------------------
  // Sequencing: opcode bit 9 selects a multi-cycle operation.
  // ------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    unique case (s_reg.st)
      U_IDLE:
      begin
        if (LINK.start)
        begin
          s_next.opc = LINK.opcode;
          s_next.st = U_LOAD;
        end
      end
      U_LOAD:
      begin
        s_next.a = LINK.op_a;
        s_next.b = LINK.op_b;
        if (!s_reg.opc[cpx_pkg::OPC_W-1])
        begin
          // Single-cycle: result valid the cycle after load.
          s_next.res = alu_y;
          s_next.cc = alu_cc;
          s_next.exc = alu_exc;
          s_next.st = U_IDLE;
        end
        else
        begin
          s_next.cnt = cpx_pkg::EU_LATENCY;
          s_next.st = U_BUSY;
        end
      end
      U_BUSY:
      begin
        s_next.cnt = s_reg.cnt - 4'h1;
        if (s_reg.cnt == 4'h1)
        begin
          // Result held until the next operation completes.
          s_next.res = alu_y;
          s_next.cc = alu_cc;
          s_next.exc = alu_exc;
          s_next.st = U_IDLE;
        end
      end
    endcase
    // Without the load strobe the unit keeps waiting and leaves its result alone.
    if (s_reg.st == U_LOAD && !LINK.load)
      s_next = s_reg;
    if (LINK.flush)
      s_next.st = U_IDLE;
    else if (s_reg.st != U_IDLE && LINK.start)
    begin
      s_next.opc = LINK.opcode;
      s_next.st = U_LOAD;
    end
  end

  // Busy, for long operations only, from the cycle after start until just before result.
  assign LINK.busy = (s_reg.st == U_LOAD && s_reg.opc[cpx_pkg::OPC_W-1]) ||
                     (s_reg.st == U_BUSY && s_reg.cnt != 4'h1);
  assign LINK.result = s_reg.res;
  assign LINK.cc = s_reg.cc;
  assign LINK.exc = s_reg.exc;

  // Register the state.
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s_reg <= '{st: U_IDLE, default: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule

// file: cpx_proc.sv
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module cpx_proc (
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Wishbone slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  // Interrupt and pipeline status
  output logic IRQ,
  output logic STALL,
  // Execution unit link
  cpx_if.proc LINK
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum {P_IDLE, P_OPER, P_WAIT} pstate_t;

  typedef struct packed {
    pstate_t st;
    logic start;
    logic load;
    logic [cpx_pkg::OPC_W-1:0] opc;
    logic [cpx_pkg::DATA_W-1:0] op_a;
    logic [cpx_pkg::DATA_W-1:0] op_b;
    logic [cpx_pkg::DATA_W-1:0] ina;
    logic [cpx_pkg::DATA_W-1:0] inb;
    logic [cpx_pkg::INSTR_W-1:0] instr;
    logic [cpx_pkg::REG_AW-1:0] rd;
    logic [cpx_pkg::REG_AW-1:0] rsel;
    logic parallel;
    logic [1:0] flush_cnt;
    logic [cpx_pkg::ST_W-1:0] stat;
    logic [cpx_pkg::ST_W-1:0] mask;
    logic [cpx_pkg::DATA_W-1:0] last_res;
    logic [cpx_pkg::CC_W-1:0] last_cc;
    logic [cpx_pkg::EXC_W-1:0] last_exc;
    logic busy_d;
    logic ack;
    logic [31:0] dat;
  } pstate_all_t;

  pstate_all_t s_reg;
  pstate_all_t s_next;
  logic [cpx_pkg::DATA_W-1:0] rf [cpx_pkg::REG_N];
  logic wb_req;
  logic wr;
  logic issue;
  logic trap;
  logic done;
  logic pending;
  logic dep;
  logic [cpx_pkg::ST_W-1:0] ev;
  logic [31:0] fsr;

  assign wb_req = WB_CYC && WB_STB && !s_reg.ack;
  assign wr = wb_req && WB_WE && WB_SEL[0];
  assign pending = (s_reg.st != P_IDLE);
  // An operation completes once busy has been low for a full cycle, so the result stands.
  assign done = (s_reg.st == P_WAIT) && !LINK.busy && !s_reg.busy_d && !s_reg.load;
  // The single unit is a resource dependency until the pending operation completes.
  assign dep = pending && !done;
  assign trap = wr && (WB_ADR == cpx_pkg::ADR_CTRL) && WB_DAT_I[cpx_pkg::CTRL_TRAP];
  assign issue = wr && (WB_ADR == cpx_pkg::ADR_INSTR);

  // Direct mode: queue flag is constant zero.
  assign fsr = {18'h00000, 1'b0, 13'h0000} | {31'h00000000, s_reg.parallel};

  // ------------------------------------------------------------
  // Control, handshake and register bus.
  // ------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    ev = '0;
    s_next.start = 1'b0;
    s_next.load = 1'b0;
    s_next.ack = wb_req;
    s_next.dat = 32'h00000000;
    s_next.busy_d = LINK.busy;
    if (s_reg.flush_cnt != 2'h0)
      s_next.flush_cnt = s_reg.flush_cnt - 2'h1;
    // Operand phase directly follows the start cycle.
    if (s_reg.start)
    begin
      s_next.load = 1'b1;
      s_next.op_a = s_reg.ina;
      s_next.op_b = s_reg.inb;
      s_next.st = P_WAIT;
    end
    if (done)
    begin
      s_next.last_res = LINK.result;
      s_next.last_cc = LINK.cc;
      s_next.last_exc = LINK.exc;
      s_next.st = P_IDLE;
      ev[cpx_pkg::ST_DONE] = 1'b1;
    end
    // Register writes.
    if (wr)
    begin
      unique case (WB_ADR)
        cpx_pkg::ADR_CTRL: s_next.parallel = WB_DAT_I[cpx_pkg::CTRL_PARALLEL];
        cpx_pkg::ADR_OPA: s_next.ina = WB_DAT_I;
        cpx_pkg::ADR_OPB: s_next.inb = WB_DAT_I;
        cpx_pkg::ADR_IMASK: s_next.mask = WB_DAT_I[cpx_pkg::ST_W-1:0];
        cpx_pkg::ADR_RDREG: s_next.rsel = WB_DAT_I[cpx_pkg::REG_AW-1:0];
        default: ;
      endcase
    end
    // Issue: store-queue traps in direct mode, else start the unit when free of dependency.
    if (issue)
    begin
      if (!s_reg.parallel && cpx_pkg::is_store_queue(WB_DAT_I))
        ev[cpx_pkg::ST_FPTRAP] = 1'b1;
      else if (!dep || done)
      begin
        // One instruction at a time; issue only when none is pending or it completes this cycle.
        s_next.start = 1'b1;
        s_next.opc = cpx_pkg::make_opcode(WB_DAT_I);
        s_next.instr = WB_DAT_I;
        s_next.rd = WB_DAT_I[cpx_pkg::RD_LSB +: cpx_pkg::REG_AW];
        s_next.st = P_OPER;
      end
    end
    // Trap abort cancels the pending instruction.
    if (trap && pending)
    begin
      s_next.flush_cnt = cpx_pkg::FLUSH_CYCLES;
      s_next.start = 1'b0;
      s_next.load = 1'b0;
      s_next.st = P_IDLE;
      ev[cpx_pkg::ST_FLUSHED] = 1'b1;
    end
    // Register reads; a read of STAT clears it, new events win.
    if (wb_req && !WB_WE)
    begin
      unique case (WB_ADR)
        cpx_pkg::ADR_CTRL: s_next.dat = {29'h00000000, s_reg.parallel, 1'b0, pending};
        cpx_pkg::ADR_INSTR: s_next.dat = s_reg.instr;
        cpx_pkg::ADR_OPA: s_next.dat = s_reg.ina;
        cpx_pkg::ADR_OPB: s_next.dat = s_reg.inb;
        cpx_pkg::ADR_STAT: s_next.dat = {29'h00000000, s_reg.stat};
        cpx_pkg::ADR_IMASK: s_next.dat = {29'h00000000, s_reg.mask};
        cpx_pkg::ADR_RESULT: s_next.dat = s_reg.last_res;
        cpx_pkg::ADR_CCEXC: s_next.dat = {24'h000000, s_reg.last_exc, s_reg.last_cc};
        cpx_pkg::ADR_FSR: s_next.dat = fsr;
        cpx_pkg::ADR_RDREG: s_next.dat = rf[s_reg.rsel];
        default: s_next.dat = 32'h00000000;
      endcase
      if (WB_ADR == cpx_pkg::ADR_STAT)
        s_next.stat = '0;
    end
    s_next.stat = s_next.stat | ev;
  end

  // Register file write-back on completion.
  always_ff @(posedge MCLK)
  begin
    if (done)
      rf[s_reg.rd] <= LINK.result;
  end

  // Register the state.
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s_reg <= '{st: P_IDLE, default: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign LINK.start = s_reg.start;
  assign LINK.opcode = s_reg.opc;
  assign LINK.load = s_reg.load;
  assign LINK.op_a = s_reg.op_a;
  assign LINK.op_b = s_reg.op_b;
  assign LINK.flush = (s_reg.flush_cnt != 2'h0);
  assign WB_ACK = s_reg.ack;
  assign WB_DAT_O = s_reg.dat;
  assign IRQ = |(s_reg.stat & s_reg.mask);
  // Direct mode stalls while anything is pending; parallel only on dependency.
  assign STALL = s_reg.parallel ? dep : pending;

endmodule

// file: cpx_link_properties.sv
`timescale 1ns/100ps
module cpx_link_properties (
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Processor to unit
  input wire logic start,
  input wire logic [cpx_pkg::OPC_W-1:0] opcode,
  input wire logic load,
  input wire logic flush,
  // Unit to processor
  input wire logic busy,
  input wire logic [cpx_pkg::DATA_W-1:0] result,
  input wire logic [cpx_pkg::CC_W-1:0] cc,
  input wire logic [cpx_pkg::EXC_W-1:0] exc
);
  // ------------------------------------------------------------
  // Link handshake checks
  // ------------------------------------------------------------
  // All checks run on the rising edge and sleep during reset.
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);

  opcode_held_a: assert property (start |=> $stable(opcode) && load)
    else $error("opcode not held or load missing after start");
  load_cause_a: assert property (load |-> $past(start))
    else $error("load without a start one cycle earlier");
  long_busy_a: assert property (start && opcode[9] |=> (busy || flush) [*4] ##1 !busy)
    else $error("busy span of a long operation is wrong");
  short_idle_a: assert property (start && !opcode[9] |=> !busy [*2])
    else $error("busy raised by a single-cycle operation");
  result_hold_a: assert property ($fell(busy) && !flush ##1 !start && !flush
    |=> $stable(result) && $stable(cc) && $stable(exc))
    else $error("result moved after a long operation ended");
  short_hold_a: assert property (load && !opcode[9] && !flush ##1 !start && !flush
    |=> $stable(result) && $stable(cc) && $stable(exc))
    else $error("result moved after a single-cycle operation");
  flush_two_a: assert property ($rose(flush) |=> flush ##1 !flush)
    else $error("flush did not last two cycles");
  flush_idle_a: assert property ($fell(flush) |-> !busy)
    else $error("unit still busy after flush");
  start_idle_a: assert property (start |-> !busy)
    else $error("start issued while unit busy");
endmodule

// file: test_coprocessor_exec_interface.sv
`timescale 1ns/100ps
module test_coprocessor_exec_interface;
  // ------------------------------------------------------------
  // Signals, instances and monitors
  // ------------------------------------------------------------
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat_w = 32'h00000000;
  logic [31:0] dat_r;
  logic ack;
  logic irq;
  logic stall;
  logic [9:0] last_opc;
  logic [31:0] rd;
  int mismatches = 0;
  int samples_checked = 0;
  int starts = 0;
  int busy_cyc = 0;
  int flush_cyc = 0;

  cpx_if i_cpx_if ();
  cpx_proc i_cpx_proc (.MCLK(mclk), .ARST_N(arst_n), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
    .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK(ack),
    .IRQ(irq), .STALL(stall), .LINK(i_cpx_if.proc));
  cpx_unit i_cpx_unit (.MCLK(mclk), .ARST_N(arst_n), .LINK(i_cpx_if.unit));
  cpx_link_properties i_props (.MCLK(mclk), .ARST_N(arst_n), .start(i_cpx_if.start),
    .opcode(i_cpx_if.opcode), .load(i_cpx_if.load), .flush(i_cpx_if.flush),
    .busy(i_cpx_if.busy), .result(i_cpx_if.result), .cc(i_cpx_if.cc), .exc(i_cpx_if.exc));

  // The clock toggles every half period of 10 ns.
  always #10 mclk = ~mclk;

  // Counts starts, busy cycles and flush cycles on the link.
  always @(posedge mclk)
  begin
    if (i_cpx_if.start === 1'b1)
    begin
      starts <= starts + 1;
      last_opc <= i_cpx_if.opcode;
    end
    if (i_cpx_if.busy === 1'b1) busy_cyc <= busy_cyc + 1;
    if (i_cpx_if.flush === 1'b1) flush_cyc <= flush_cyc + 1;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One classic Wishbone cycle; read data lands in rd.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    @(posedge mclk);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 20) mismatches++;
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask

  // Polls the pending flag until the operation has ended.
  task automatic wait_idle;
    int n;
    n = 0;
    rd = 32'h00000001;
    while (rd[0] !== 1'b0 && n < 30)
    begin
      wb(1'b0, cpx_pkg::ADR_CTRL, 32'h00000000);
      n++;
    end
    chk(32'(rd[0]), 32'h00000000, "pending");
  endtask

  function automatic logic [31:0] mk(input logic b19, input logic [8:0] lo, input logic [4:0] r);
    return {2'h2, r, 5'h00, b19, 5'h00, lo, 5'h00};
  endfunction

  task automatic report_and_stop;
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Short operations with several opcode patterns, no interrupt.
  task automatic t_short;
    logic [8:0] lo;
    wb(1'b1, cpx_pkg::ADR_IMASK, 32'h00000000);
    for (int i = 0; i < 3; i++)
    begin
      lo = 9'h1FF >> (i * 4);
      wb(1'b1, cpx_pkg::ADR_OPA, 32'h00000010 << i);
      wb(1'b1, cpx_pkg::ADR_INSTR, mk(1'b0, lo, 5'h01));
      chk(32'(last_opc), 32'({1'b0, lo}), "opcode");
      wait_idle;
      // Operand B stays zero, so both exclusive-or and subtract return operand A.
      wb(1'b0, cpx_pkg::ADR_RESULT, 32'h00000000);
      chk(rd, 32'h00000010 << i, "short result");
    end
    chk(32'(irq), 32'h00000000, "masked irq");
    wb(1'b0, cpx_pkg::ADR_STAT, 32'h00000000);
    chk(rd & 32'h00000001, 32'h00000001, "done flag");
  endtask

  // Long operation in direct mode with interrupt and write-back.
  task automatic t_long;
    logic [31:0] r;
    int s0;
    s0 = busy_cyc;
    wb(1'b1, cpx_pkg::ADR_IMASK, 32'h00000001);
    wb(1'b1, cpx_pkg::ADR_INSTR, mk(1'b1, 9'h003, 5'h07));
    chk(32'(last_opc), 32'h00000203, "long opcode");
    chk(32'(stall), 32'h00000001, "stall");
    wait_idle;
    chk(32'(busy_cyc - s0), 32'h00000004, "busy span");
    chk(32'(irq), 32'h00000001, "irq set");
    wb(1'b0, cpx_pkg::ADR_STAT, 32'h00000000);
    chk(32'(irq), 32'h00000000, "irq cleared");
    wb(1'b0, cpx_pkg::ADR_RESULT, 32'h00000000);
    r = rd;
    chk(i_cpx_if.result, r, "link result");
    chk(r, 32'h00000040, "long result");
    wb(1'b0, cpx_pkg::ADR_CCEXC, 32'h00000000);
    chk(rd, 32'h00000000, "cc and exc");
    wb(1'b0, cpx_pkg::ADR_INSTR, 32'h00000000);
    chk(rd, mk(1'b1, 9'h003, 5'h07), "instr readback");
    wb(1'b1, cpx_pkg::ADR_RDREG, 32'h00000007);
    wb(1'b0, cpx_pkg::ADR_RDREG, 32'h00000000);
    chk(rd, r, "write-back");
  endtask

  // Trap abort in the middle of a long operation.
  task automatic t_flush;
    int s0;
    s0 = flush_cyc;
    wb(1'b1, cpx_pkg::ADR_INSTR, mk(1'b1, 9'h011, 5'h02));
    wb(1'b1, cpx_pkg::ADR_CTRL, 32'h00000002);
    wait_idle;
    chk(32'(flush_cyc - s0), 32'h00000002, "flush length");
    chk(32'(i_cpx_if.busy), 32'h00000000, "idle after flush");
    wb(1'b0, cpx_pkg::ADR_STAT, 32'h00000000);
    chk(rd & 32'h00000002, 32'h00000002, "flushed flag");
  endtask

  // Queue flag, store-queue trap, parallel mode and refused issue.
  task automatic t_modes;
    int s0;
    int s1;
    wb(1'b0, cpx_pkg::ADR_FSR, 32'h00000000);
    chk(rd & 32'h00002001, 32'h00000000, "direct fsr");
    wb(1'b1, cpx_pkg::ADR_INSTR, {2'h3, 5'h00, 6'h26, 19'h00000});
    wb(1'b0, cpx_pkg::ADR_STAT, 32'h00000000);
    chk(rd & 32'h00000004, 32'h00000004, "store-queue trap");
    wb(1'b1, cpx_pkg::ADR_CTRL, 32'h00000004);
    wb(1'b0, cpx_pkg::ADR_FSR, 32'h00000000);
    chk(rd & 32'h00002001, 32'h00000001, "parallel fsr");
    s0 = starts;
    s1 = busy_cyc;
    wb(1'b1, cpx_pkg::ADR_INSTR, mk(1'b1, 9'h021, 5'h03));
    wb(1'b1, cpx_pkg::ADR_INSTR, mk(1'b1, 9'h022, 5'h04));
    wait_idle;
    chk(32'(starts - s0), 32'h00000001, "dependent issue");
    chk(32'(busy_cyc - s1), 32'h00000004, "parallel busy");
    wb(1'b0, 8'h40, 32'h00000000);
    chk(rd, 32'h00000000, "unmapped read");
  endtask

  // Main sequence: reset for four cycles, then every scenario.
  initial
  begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    chk({30'h00000000, irq, stall}, 32'h00000000, "reset outputs");
    t_short;
    t_long;
    t_flush;
    t_modes;
    report_and_stop;
  end

  // Watchdog well beyond the expected run of under two hundred cycles.
  initial
  begin
    #200000;
    mismatches++;
    report_and_stop;
  end
endmodule
